//--- logic/err_consts.svh
`ifndef ERR_CONSTS_SVH
`define ERR_CONSTS_SVH
`define NSRC 4
`define CNT_W 16
`define OFF_BANK_EN 8'h00
`define OFF_REP_EN 8'h04
`define OFF_ACT_DIS 8'h08
`define OFF_GSTAT 8'h0c
`define OFF_INT_CTL 8'h10
`define OFF_INT_STAT 8'h14
`define OFF_THRESH 8'h18
`define OFF_CORR_CNT 8'h1c
`define BANK_HI 4'h2
`define GS_CHECK_IN_PROGRESS_FLAG 2
`define GS_SHUT 3
`define GS_DEF_LO 8
`define IC_DEF 0
`define IC_THR 1
`define BS_VALID 0
`define BS_CLS_LO 1
`define BS_RECOV 3
`define BS_POISON 4
`define BS_OVF 5
`define RST_EN 4'h0
`define RST_THRESH 16'hffff
`endif

//--- logic/err_pkg.sv
package err_pkg;
  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_CORR,
    CLS_DEFER,
    CLS_UNCORR
  } err_class_t;

  typedef struct packed {
    logic valid;
    logic [1:0] src;
    logic correctable;
    logic no_impact;
    logic poison;
    logic uncontainable;
    logic state_corrupt;
  } err_evt_t;

  typedef struct packed {
    logic valid;
    logic [1:0] src;
  } consume_t;

  typedef struct packed {
    logic valid;
    err_class_t cls;
    logic recov;
    logic poison;
    logic ovf;
  } log_rec_t;
endpackage : err_pkg

//--- logic/error_log_report_classifier.sv
`timescale 1ns/1ps
`include "err_consts.svh"
module error_log_report_classifier (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire err_pkg::err_evt_t err_evt,
  input wire err_pkg::consume_t consume,
  output logic machine_check_exception,
  output logic corrected_done,
  output logic contain_done,
  output logic core_shutdown,
  output logic deferred_irq,
  output logic threshold_irq
);
  logic [`NSRC-1:0] bank_en_r;
  logic [`NSRC-1:0] rep_en_r;
  logic [`NSRC-1:0] act_dis_r;
  logic [1:0] int_en_r;
  logic [1:0] int_pend_r;
  logic [`CNT_W-1:0] thresh_r;
  logic [`CNT_W-1:0] corr_cnt_r;
  logic [`NSRC-1:0] def_pend_r;
  logic check_in_progress_flag_r;
  logic shut_r;
  logic mce_r;
  logic corr_r;
  logic cont_r;
  logic bad_r;
  logic [31:0] prdata_r;
  err_pkg::log_rec_t rec_r [`NSRC];

  err_pkg::err_class_t cls;
  logic ev_ok;
  logic log_hit;
  logic esc;
  logic mce_fire;
  logic shut_fire;
  logic acc;
  logic wr;
  logic is_bank;
  logic [1:0] bidx;
  logic hit;

  // classification: correction first, then deferral, else uncorrected
  always_comb begin
    cls = err_pkg::CLS_NONE;
    ev_ok = err_evt.valid & ~shut_r;
    if (ev_ok) begin
      if (err_evt.correctable & ~act_dis_r[err_evt.src]) begin
        cls = err_pkg::CLS_CORR;
      end else if ((err_evt.no_impact | err_evt.poison) &
                   ~err_evt.uncontainable &
                   ~act_dis_r[err_evt.src]) begin
        cls = err_pkg::CLS_DEFER;
      end else begin
        cls = err_pkg::CLS_UNCORR;
      end
    end
  end

  // logging is gated by the bank enable and by shutdown, never by reporting
  assign log_hit = ev_ok & bank_en_r[err_evt.src];
  assign esc = consume.valid & ~shut_r & def_pend_r[consume.src];
  // corrected errors never reach the machine check; deferred ones reach it only when consumed
  assign mce_fire = ((cls == err_pkg::CLS_UNCORR) &
                     rep_en_r[err_evt.src]) |
                    (esc & rep_en_r[consume.src]);
  assign shut_fire = (ev_ok & err_evt.uncontainable) |
                     (mce_fire & check_in_progress_flag_r);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mce_r <= 1'b0;
      shut_r <= 1'b0;
    end else begin
      mce_r <= mce_fire & ~shut_fire;
      if (shut_fire) begin
        shut_r <= 1'b1;
      end
    end
  end

  // hardware action strobes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      corr_r <= 1'b0;
      cont_r <= 1'b0;
    end else begin
      corr_r <= (cls == err_pkg::CLS_CORR);
      cont_r <= (cls == err_pkg::CLS_DEFER) |
                (cls == err_pkg::CLS_UNCORR & ~err_evt.uncontainable &
                 ~act_dis_r[err_evt.src]);
    end
  end

  // apb decode
  assign acc = psel & penable;
  assign wr = acc & pwrite & ~bad_r;
  assign is_bank = paddr[7:4] == `BANK_HI;
  assign bidx = paddr[3:2];
  always_comb begin
    case (paddr)
      `OFF_BANK_EN, `OFF_REP_EN, `OFF_ACT_DIS, `OFF_GSTAT,
      `OFF_INT_CTL, `OFF_INT_STAT, `OFF_THRESH, `OFF_CORR_CNT: hit = 1'b1;
      default: hit = is_bank & (paddr[1:0] == 2'h0);
    endcase
  end

  // software configuration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_en_r <= `RST_EN;
      rep_en_r <= `RST_EN;
      act_dis_r <= `RST_EN;
      int_en_r <= 2'h0;
      thresh_r <= `RST_THRESH;
    end else if (wr) begin
      case (paddr)
        `OFF_BANK_EN: bank_en_r <= pwdata[`NSRC-1:0];
        `OFF_REP_EN: rep_en_r <= pwdata[`NSRC-1:0];
        `OFF_ACT_DIS: act_dis_r <= pwdata[`NSRC-1:0];
        `OFF_INT_CTL: int_en_r <= pwdata[1:0];
        `OFF_THRESH: thresh_r <= pwdata[`CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // in-progress flag: a new exception wins over a software clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      check_in_progress_flag_r <= 1'b0;
    end else begin
      if (wr & (paddr == `OFF_GSTAT) & pwdata[`GS_CHECK_IN_PROGRESS_FLAG]) begin
        check_in_progress_flag_r <= 1'b0;
      end
      if (mce_fire & ~shut_fire) begin
        check_in_progress_flag_r <= 1'b1;
      end
    end
  end

  // deferred tracking runs whether or not the bank logs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      def_pend_r <= '0;
    end else begin
      if (esc) begin
        def_pend_r[consume.src] <= 1'b0;
      end
      if (cls == err_pkg::CLS_DEFER) begin
        def_pend_r[err_evt.src] <= 1'b1;
      end
    end
  end

  // corrected-error counter, saturating; a write reloads it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      corr_cnt_r <= '0;
    end else if (wr & (paddr == `OFF_CORR_CNT)) begin
      corr_cnt_r <= pwdata[`CNT_W-1:0];
    end else if (log_hit & (cls == err_pkg::CLS_CORR) &
                 ~(&corr_cnt_r)) begin
      corr_cnt_r <= corr_cnt_r + `CNT_W'(1);
    end
  end

  // notification interrupts; sticky, write one to clear, set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_pend_r <= 2'h0;
    end else begin
      if (wr & (paddr == `OFF_INT_STAT)) begin
        int_pend_r <= int_pend_r & ~pwdata[1:0];
      end
      // keyed to a deferral on a source with none pending yet, not to reporting enables
      if (int_en_r[`IC_DEF] & (cls == err_pkg::CLS_DEFER) &
          ~def_pend_r[err_evt.src]) begin
        int_pend_r[`IC_DEF] <= 1'b1;
      end
      // the step from threshold to threshold plus one exceeds it
      if (int_en_r[`IC_THR] & log_hit & (cls == err_pkg::CLS_CORR) &
          (corr_cnt_r == thresh_r) & ~(&corr_cnt_r)) begin
        int_pend_r[`IC_THR] <= 1'b1;
      end
    end
  end

  // per-source log records; a second error before a write clears the bank sets overflow
  for (genvar i = 0; i < `NSRC; i++) begin : g_bank
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        rec_r[i] <= '0;
      end else begin
        if (wr & is_bank & (bidx == 2'(i))) begin
          rec_r[i] <= '0;
        end
        if (esc & (consume.src == 2'(i)) & rec_r[i].valid &
            (rec_r[i].cls == err_pkg::CLS_DEFER)) begin
          rec_r[i].cls <= err_pkg::CLS_UNCORR;
          rec_r[i].recov <= 1'b1;
        end
        // disabled banks drop the record entirely
        if (log_hit & (err_evt.src == 2'(i))) begin
          if (rec_r[i].valid &
              ~(wr & is_bank & (bidx == 2'(i)))) begin
            rec_r[i].ovf <= 1'b1;
          end else begin
            rec_r[i].valid <= 1'b1;
            rec_r[i].cls <= cls;
            rec_r[i].recov <= ~err_evt.state_corrupt &
                              ~err_evt.uncontainable;
            rec_r[i].poison <= err_evt.poison;
            rec_r[i].ovf <= 1'b0;
          end
        end
      end
    end
  end

  // read data is latched in the setup cycle so it leaves a flip-flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= '0;
      bad_r <= 1'b0;
    end else if (psel & ~penable) begin
      bad_r <= ~hit;
      prdata_r <= '0;
      if (is_bank) begin
        prdata_r[`BS_VALID] <= rec_r[bidx].valid;
        prdata_r[`BS_CLS_LO+1:`BS_CLS_LO] <= rec_r[bidx].cls;
        prdata_r[`BS_RECOV] <= rec_r[bidx].recov;
        prdata_r[`BS_POISON] <= rec_r[bidx].poison;
        prdata_r[`BS_OVF] <= rec_r[bidx].ovf;
      end else begin
        case (paddr)
          `OFF_BANK_EN: prdata_r[`NSRC-1:0] <= bank_en_r;
          `OFF_REP_EN: prdata_r[`NSRC-1:0] <= rep_en_r;
          `OFF_ACT_DIS: prdata_r[`NSRC-1:0] <= act_dis_r;
          `OFF_GSTAT: begin
            prdata_r[`GS_CHECK_IN_PROGRESS_FLAG] <= check_in_progress_flag_r;
            prdata_r[`GS_SHUT] <= shut_r;
            prdata_r[`GS_DEF_LO+`NSRC-1:`GS_DEF_LO] <= def_pend_r;
          end
          `OFF_INT_CTL: prdata_r[1:0] <= int_en_r;
          `OFF_INT_STAT: prdata_r[1:0] <= int_pend_r;
          `OFF_THRESH: prdata_r[`CNT_W-1:0] <= thresh_r;
          `OFF_CORR_CNT: prdata_r[`CNT_W-1:0] <= corr_cnt_r;
          default: ;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = acc;
  assign pslverr = acc & bad_r;
  assign machine_check_exception = mce_r;
  assign corrected_done = corr_r;
  assign contain_done = cont_r;
  assign core_shutdown = shut_r;
  assign deferred_irq = int_pend_r[`IC_DEF];
  assign threshold_irq = int_pend_r[`IC_THR];
endmodule : error_log_report_classifier

//--- testbench/error_log_report_classifier_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("Error %s exp %h got %h", n, e, g); end end
module error_log_report_classifier_bench;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, r;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, machine_check_exception, corrected_done;
  logic contain_done, core_shutdown, deferred_irq, threshold_irq;
  logic [1:0] s;
  logic [4:0] f;
  err_pkg::err_evt_t err_evt = '0;
  err_pkg::consume_t consume = '0;
  int errors = 0, samples_checked = 0, cyc = 0;
  integer seed = 32'h1ab7f327;
  always #2 core_clk = ~core_clk;
  error_log_report_classifier i_error_log_report_classifier (.core_clk,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .err_evt, .consume, .machine_check_exception, .corrected_done,
    .contain_done, .core_shutdown, .deferred_irq, .threshold_irq);
  task stop_test();
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(0, a, 0);
    `CHK("register", e, rd & m)
  endtask : rc
  // outputs are registered: look just after the edge that samples the event
  task fire(input err_pkg::err_evt_t e, input err_pkg::consume_t c,
            input logic [2:0] x);
    @(posedge core_clk);
    err_evt <= e; consume <= c;
    @(posedge core_clk);
    err_evt <= '0; consume <= '0;
    #1 `CHK("outputs", x, {machine_check_exception, corrected_done,
      contain_done})
  endtask : fire
  function err_pkg::err_evt_t ev(input logic [1:0] q, input logic [4:0] b);
    return {1'b1, q, b};
  endfunction : ev
  // expected {check, corrected, contained} with flag clear and source on
  function logic [2:0] xp(input logic [4:0] b);
    logic c, k;
    c = b[4];
    k = !c && (b[3] || b[2]) && !b[1];
    // containment covers deferred and containable uncorrected errors
    return {!c && !k, c, !c && !b[1]};
  endfunction : xp
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1;
    rc(8'h18, 32'hffff, '1);
    rc(8'h04, 0, '1);
    apb(0, 8'h30, 0);
    `CHK("slverr", 1'b1, er)
    apb(1, 8'h00, 32'hf);
    apb(1, 8'h04, 32'hf);
    apb(1, 8'h10, 32'h3);
    s = $random(seed);
    r = 8'h20 + {4'h0, s, 2'b00};
    fire(ev(s, 5'b10000), 0, 3'b010);
    rc(r, 32'h3, 32'h7);
    apb(1, r, 0);
    fire(ev(s, 5'b00000), 0, 3'b101);
    rc(8'h0c, 32'h4, 32'h4);
    rc(r, 32'hf, 32'hf);
    apb(1, 8'h0c, 4);
    apb(1, r, 0);
    fire(ev(s, 5'b00001), 0, 3'b101);
    rc(r, 32'h7, 32'hf);
    apb(1, 8'h0c, 4);
    apb(1, r, 0);
    fire(ev(s, 5'b01000), 0, 3'b001);
    `CHK("deferred irq", 1'b1, deferred_irq)
    rc(r, 32'h5, 32'h7);
    fire(0, {1'b1, s}, 3'b100);
    rc(r, 32'h7, 32'h7);
    apb(1, 8'h0c, 4);
    apb(1, 8'h14, 1);
    #1 `CHK("deferred irq", 1'b0, deferred_irq)
    apb(1, r, 0);
    apb(1, 8'h04, 0);
    fire(ev(s, 5'b00000), 0, 3'b001);
    rc(r, 32'h7, 32'h7);
    fire(ev(s + 2'd1, 5'b00100), 0, 3'b001);
    fire(0, {1'b1, s + 2'd1}, 3'b000);
    `CHK("deferred irq", 1'b1, deferred_irq)
    apb(1, 8'h04, 32'hf);
    fire(ev(s, 5'b00100), 0, 3'b001);
    fire(0, {1'b1, s}, 3'b100);
    apb(1, 8'h0c, 4);
    apb(1, 8'h00, 0);
    // neighbour bank, wrapped so it always stays inside the map
    r = 8'h20 + {4'h0, s + 2'd1, 2'b00};
    apb(1, r, 0);
    fire(ev(s + 2'd1, 5'b10000), 0, 3'b010);
    rc(r, 0, 32'h1);
    apb(1, 8'h00, 32'hf);
    apb(1, 8'h08, 32'hf);
    fire(ev(s, 5'b10000), 0, 3'b100);
    apb(1, 8'h08, 0);
    apb(1, 8'h0c, 4);
    repeat (8) begin
      f = $random(seed);
      f[1] = 1'b0;
      fire(ev(2'($random(seed)), f), 0, xp(f));
      apb(1, 8'h0c, 4);
    end
    apb(1, 8'h18, 2);
    apb(1, 8'h1c, 1);
    fire(ev(s, 5'b10000), 0, 3'b010);
    `CHK("threshold irq", 1'b0, threshold_irq)
    fire(ev(s, 5'b10000), 0, 3'b010);
    `CHK("threshold irq", 1'b1, threshold_irq)
    rc(8'h1c, 32'h3, 32'hffff);
    fire(ev(s, 5'b00000), 0, 3'b101);
    fire(ev(s, 5'b00000), 0, 3'b001);
    `CHK("shutdown", 1'b1, core_shutdown)
    fire(ev(s, 5'b10000), 0, 3'b000);
    rst_n <= 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    apb(1, 8'h04, 32'hf);
    fire(ev(s, 5'b01010), 0, 3'b000);
    `CHK("shutdown", 1'b1, core_shutdown)
    stop_test();
  end
endmodule : error_log_report_classifier_bench

//--- testbench/error_log_report_classifier_sva.sv
`timescale 1ns/1ps
module error_log_report_classifier_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire err_pkg::err_evt_t err_evt,
  input wire err_pkg::consume_t consume,
  input wire logic machine_check_exception,
  input wire logic corrected_done,
  input wire logic contain_done,
  input wire logic core_shutdown,
  input wire logic deferred_irq,
  input wire logic threshold_irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_check;
    machine_check_exception;
  endsequence
  sequence s_shut_held;
    core_shutdown ##1 core_shutdown;
  endsequence
  a_corr_no_mce: assert property (
    corrected_done |-> !machine_check_exception)
    else $error("check raised with corrected event");
  a_one_class: assert property (
    corrected_done |-> !contain_done)
    else $error("two classes for one event");
  a_no_back2back: assert property (
    s_check |=> !machine_check_exception)
    else $error("second check while in progress");
  a_check_cause: assert property (
    s_check |-> $past(err_evt.valid || consume.valid))
    else $error("check without a cause");
  a_shut_sticky: assert property (
    core_shutdown |=> core_shutdown)
    else $error("shutdown dropped");
  a_shut_cause: assert property (
    $rose(core_shutdown) |-> $past(err_evt.valid || consume.valid))
    else $error("shutdown without a cause");
  a_shut_quiet: assert property (
    s_shut_held |-> !machine_check_exception && !corrected_done &&
    !contain_done)
    else $error("activity after shutdown");
  a_out_cause: assert property (
    corrected_done || contain_done |-> $past(err_evt.valid))
    else $error("action pulse without event");
  a_dirq_cause: assert property (
    $rose(deferred_irq) |-> $past(err_evt.valid))
    else $error("deferred interrupt without event");
  a_ready_now: assert property (
    psel && penable |-> pready)
    else $error("access not answered at once");
endmodule : error_log_report_classifier_sva
bind error_log_report_classifier error_log_report_classifier_sva i_sva (
  .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .err_evt, .consume, .machine_check_exception,
  .corrected_done, .contain_done, .core_shutdown, .deferred_irq,
  .threshold_irq
);
